/* mtios_pkg.sv */
// package for the motion task i/o selector: field layouts, defaults, timing
// assumes a single core clock of 25 MHz and a classic wishbone register bus
package mtios_pkg;

	// clock and timing
	localparam int CLK_HZ = 25000000;
	localparam int STATUS_MAX_MS = 10;
	localparam int STATUS_MAX_CYC = (CLK_HZ / 1000) * STATUS_MAX_MS;
	localparam int DEBOUNCE_US = 1000;
	localparam int DEBOUNCE_CYC = (CLK_HZ / 1000000) * DEBOUNCE_US;

	// register word offsets (byte addresses)
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_TASK = 8'h08;
	localparam logic [7:0] REG_IN_MAP = 8'h0C;
	localparam logic [7:0] REG_OUT_MAP = 8'h10;
	localparam logic [7:0] REG_POS = 8'h14;

	// control bit positions
	localparam int CTRL_BASE_HOME = 0;
	localparam int CTRL_BASE_NEXT = 1;
	localparam int CTRL_STEP_MODE = 2;
	localparam int CTRL_OUT0_SEL = 4;
	localparam logic [7:0] CTRL_RESET = 8'h00;

	// default pin map: identity, 14 inputs / 3 outputs
	localparam int N_IN = 14;
	localparam int N_OUT = 3;
	localparam logic [55:0] IN_MAP_RESET = 56'hDCBA9876543210;
	localparam logic [5:0] OUT_MAP_RESET = 6'h24;

	// input function indices in the mapped vector
	localparam int IN_SEL0 = 0;
	localparam int IN_HOME = 8;
	localparam int IN_CLR = 9;
	localparam int IN_NEXT = 10;
	localparam int IN_JOG = 11;
	localparam int IN_RESUME = 12;
	localparam int IN_GO = 13;

	// next-in-position signalling forms
	typedef enum logic [1:0] {
		MTIOS_STEP_TOGGLE = 2'h0,
		MTIOS_STEP_PULSE = 2'h1,
		MTIOS_STEP_LEVEL = 2'h2
	} mtios_step_mode_t;

	// motion requests toward the motion core: one-cycle pulses, plus block number and home switch levels
	typedef struct packed {
		logic go;
		logic resume;
		logic next_go;
		logic jog_start;
		logic jog_stop;
		logic home_sw;
		logic warn_clear;
		logic [7:0] block;
	} mtios_req_t;

	// motion core status back to the selector
	typedef struct packed {
		logic in_window;
		logic task_started;
		logic seq_first;
		logic seq_active;
		logic window0;
	} mtios_stat_t;

endpackage : mtios_pkg

/* mtios_debounce.sv */
// debouncer bank: two-stage sync then a stability counter per input
// assumes inputs asynchronous-safe after the sync, one core clock
`timescale 1ns/10ps
`default_nettype none
module mtios_debounce #(
	parameter int WIDTH = 14,
	parameter int COUNT = 25000
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] raw,
	output logic [WIDTH-1:0] clean
);
	localparam int CW = $clog2(COUNT + 1);

	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
		logic [WIDTH-1:0] out;
		logic [WIDTH-1:0][CW-1:0] cnt;
	} mtios_db_t;

	mtios_db_t st;
	mtios_db_t next_st;

	initial begin
		if (COUNT < 1) $error("debounce count must be at least one");
	end

	// sync first, then require a steady level for COUNT cycles
	always_comb begin
		next_st = st;
		next_st.s1 = raw;
		next_st.s2 = st.s1;
		for (int i = 0; i < WIDTH; i++) begin
			if (st.s2[i] == st.out[i]) begin
				next_st.cnt[i] = '0;
			end else if (st.cnt[i] == CW'(COUNT - 1)) begin
				next_st.cnt[i] = '0;
				next_st.out[i] = st.s2[i];
			end else begin
				next_st.cnt[i] = st.cnt[i] + CW'(1);
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign clean = st.out;
endmodule : mtios_debounce
`default_nettype wire

/* mtios_selector.sv */
// motion task i/o selector: pins to motion requests, status to pins
// assumes a motion core that consumes one-cycle requests and reports status
`timescale 1ns/10ps
`default_nettype none
module mtios_selector #(
	parameter int DEBOUNCE_CYC = mtios_pkg::DEBOUNCE_CYC
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [13:0] card_in,
	input wire logic base_home_in,
	input wire logic base_next_in,
	input wire logic [31:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic wb_we_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire mtios_pkg::mtios_stat_t core_stat,
	output mtios_pkg::mtios_req_t core_req,
	output logic [2:0] card_out
);
	typedef struct packed {
		logic [31:0] dat;
		logic ack;
		logic [7:0] ctrl;
		logic [55:0] in_map;
		logic [5:0] out_map;
		logic [13:0] prev;
		logic base_next_prev;
		logic next_pending;
		logic lag_warn;
		logic watch_warn;
		logic step;
		mtios_pkg::mtios_req_t req;
		logic [2:0] pins;
	} mtios_sel_t;

	mtios_sel_t st;
	mtios_sel_t next_st;
	logic [13:0] clean;
	logic [13:0] fn;
	logic [1:0] base_s1;
	logic [1:0] base_s2;
	logic [2:0] out_fn;

	initial begin
		if (DEBOUNCE_CYC < 1) $error("debounce count must be at least one");
		if (mtios_pkg::STATUS_MAX_CYC < 2) $error("status bound too small");
	end

	// pick one bit out of a vector by a 4-bit index
	function automatic logic pick14(input logic [13:0] v, input logic [3:0] i);
		pick14 = (i < 4'hE) ? v[i] : 1'b0;
	endfunction : pick14

	// byte-lane merge for a wishbone write
	function automatic logic [31:0] lane_merge(input logic [31:0] old,
			input logic [31:0] wd, input logic [3:0] sel);
		lane_merge = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) lane_merge[b*8 +: 8] = wd[b*8 +: 8];
		end
	endfunction : lane_merge

	// card pins debounced before any edge logic
	mtios_debounce #(
		.WIDTH(14),
		.COUNT(DEBOUNCE_CYC)
	) u_db (
		.core_clk(core_clk),
		.rst(rst),
		.raw(card_in),
		.clean(clean)
	);

	// base-unit inputs: two-stage sync, second stage only is read
	always_ff @(posedge core_clk) begin
		if (rst) begin
			base_s1 <= 2'h0;
			base_s2 <= 2'h0;
		end else begin
			base_s1 <= {base_next_in, base_home_in};
			base_s2 <= base_s1;
		end
	end

	// map physical pins onto functions through the input map
	always_comb begin
		for (int f = 0; f < 14; f++) begin
			fn[f] = pick14(clean, st.in_map[f*4 +: 4]);
		end
	end

	// output functions: 0 in-pos, 1 step flag, 2 window output zero, or lag warning when CTRL_OUT0_SEL is set
	always_comb begin
		out_fn[0] = core_stat.in_window;
		out_fn[1] = st.step;
		out_fn[2] = st.ctrl[mtios_pkg::CTRL_OUT0_SEL] ? st.lag_warn
			: core_stat.window0;
	end

	// main next-state logic: bus, edge detection, requests, outputs
	always_comb begin
		logic [13:0] rise;
		logic [13:0] fall;
		logic base_next_rise;
		logic [31:0] wv;
		logic wr;
		mtios_pkg::mtios_step_mode_t mode;
		rise = '0;
		fall = '0;
		base_next_rise = 1'b0;
		wv = '0;
		wr = 1'b0;
		mode = mtios_pkg::MTIOS_STEP_TOGGLE;
		next_st = st;
		next_st.req = '0;
		rise = fn & ~st.prev;
		fall = ~fn & st.prev;
		next_st.prev = fn;
		base_next_rise = base_s2[1] & ~st.base_next_prev;
		next_st.base_next_prev = base_s2[1];
		mode = mtios_pkg::mtios_step_mode_t'(
			st.ctrl[mtios_pkg::CTRL_STEP_MODE +: 2]);

		// block number, first select input as lsb
		next_st.req.block = fn[mtios_pkg::IN_SEL0 +: 8];
		next_st.req.go = rise[mtios_pkg::IN_GO];
		next_st.req.resume = rise[mtios_pkg::IN_RESUME];
		next_st.req.jog_start = rise[mtios_pkg::IN_JOG];
		next_st.req.jog_stop = fall[mtios_pkg::IN_JOG];
		// home source: base unit when CTRL_BASE_HOME is set, card pin otherwise
		next_st.req.home_sw = st.ctrl[mtios_pkg::CTRL_BASE_HOME]
			? base_s2[0] : fn[mtios_pkg::IN_HOME];

		// next-task request waits for target position
		if (rise[mtios_pkg::IN_NEXT]
				|| (st.ctrl[mtios_pkg::CTRL_BASE_NEXT] && base_next_rise)) begin
			next_st.next_pending = 1'b1;
		end
		if (next_st.next_pending && core_stat.in_window) begin
			next_st.req.next_go = 1'b1;
			next_st.next_pending = 1'b0;
		end

		// warnings set by software status writes, error clear wipes both
		if (fn[mtios_pkg::IN_CLR]) begin
			next_st.lag_warn = 1'b0;
			next_st.watch_warn = 1'b0;
		end
		next_st.req.warn_clear = rise[mtios_pkg::IN_CLR];

		// next-in-position signalling
		unique case (mode)
			mtios_pkg::MTIOS_STEP_TOGGLE: begin
				if (core_stat.task_started && core_stat.seq_active) begin
					next_st.step = core_stat.seq_first ? 1'b0 : ~st.step;
				end
			end
			mtios_pkg::MTIOS_STEP_PULSE: begin
				next_st.step = core_stat.task_started && core_stat.seq_active;
			end
			mtios_pkg::MTIOS_STEP_LEVEL: begin
				next_st.step = core_stat.seq_active;
			end
			default: begin
				next_st.step = 1'b0;
			end
		endcase

		// output pins through the output map, refreshed every cycle
		for (int p = 0; p < 3; p++) begin
			next_st.pins[p] = (st.out_map[p*2 +: 2] < 2'h3)
				? out_fn[st.out_map[p*2 +: 2]] : 1'b0;
		end

		// wishbone classic slave, one wait state, ack dropped after one cycle
		next_st.ack = 1'b0;
		wr = wb_cyc_i && wb_stb_i && !st.ack;
		if (wr) begin
			next_st.ack = 1'b1;
			next_st.dat = '0;
			unique case (wb_adr_i[7:0])
				mtios_pkg::REG_CTRL: begin
					next_st.dat = {24'h000000, st.ctrl};
					if (wb_we_i) begin
						wv = lane_merge({24'h000000, st.ctrl}, wb_dat_i, wb_sel_i);
						next_st.ctrl = wv[7:0];
					end
				end
				mtios_pkg::REG_STATUS: begin
					next_st.dat = {26'h0000000, st.watch_warn, st.lag_warn,
						st.next_pending, st.step, st.pins[0], core_stat.in_window};
					if (wb_we_i) begin
						// software may raise warnings for the core side
						if (wb_sel_i[0] && wb_dat_i[4]) next_st.lag_warn = 1'b1;
						if (wb_sel_i[0] && wb_dat_i[5]) next_st.watch_warn = 1'b1;
					end
				end
				mtios_pkg::REG_TASK: begin
					next_st.dat = {18'h00000, fn};
				end
				mtios_pkg::REG_IN_MAP: begin
					next_st.dat = st.in_map[31:0];
					if (wb_we_i) begin
						next_st.in_map[31:0] = lane_merge(st.in_map[31:0],
							wb_dat_i, wb_sel_i);
					end
				end
				mtios_pkg::REG_OUT_MAP: begin
					// upper input map bytes above the output map field
					next_st.dat = {st.in_map[55:32], 2'h0, st.out_map};
					if (wb_we_i) begin
						if (wb_sel_i[0]) next_st.out_map = wb_dat_i[5:0];
						if (wb_sel_i[1]) next_st.in_map[39:32] = wb_dat_i[15:8];
						if (wb_sel_i[2]) next_st.in_map[47:40] = wb_dat_i[23:16];
						if (wb_sel_i[3]) next_st.in_map[55:48] = wb_dat_i[31:24];
					end
				end
				default: begin
					next_st.dat = '0;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			st <= '0;
			st.ctrl <= mtios_pkg::CTRL_RESET;
			st.in_map <= mtios_pkg::IN_MAP_RESET;
			st.out_map <= mtios_pkg::OUT_MAP_RESET;
		end else begin
			st <= next_st;
		end
	end

	assign wb_dat_o = st.dat;
	assign wb_ack_o = st.ack;
	assign core_req = st.req;
	assign card_out = st.pins;
endmodule : mtios_selector
`default_nettype wire

/* mtios_checker.sv */
// checker: bus answer, request pulses and status pin timing
// assumes default output map and toggle step form
`timescale 1ns/10ps
`default_nettype none
module mtios_checker (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire mtios_pkg::mtios_stat_t core_stat,
	input wire mtios_pkg::mtios_req_t core_req,
	input wire logic [2:0] card_out
);
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (rst);
	// a sequence step reported by the core
	sequence s_step;
		core_stat.task_started && core_stat.seq_active;
	endsequence
	// bus answer comes next cycle and lasts one
	a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("bus answer late");
	a_ack_drop: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("bus answer held");
	// motion requests
	a_go_pulse: assert property (core_req.go |=> !core_req.go)
		else $error("start held");
	a_jog_apart: assert property (!(core_req.jog_start && core_req.jog_stop))
		else $error("jog start and stop");
	a_next_gated: assert property (core_req.next_go |-> $past(core_stat.in_window))
		else $error("next before target");
	// status pins
	a_target_reached_high: assert property (core_stat.in_window [*3] |-> card_out[0])
		else $error("in-position low");
	a_target_reached_low: assert property (!core_stat.in_window [*3] |-> !card_out[0])
		else $error("in-position high");
	a_first_low: assert property (s_step ##0 core_stat.seq_first |-> ##2 !card_out[1])
		else $error("first step not low");
	a_step_flip: assert property (s_step ##0 !core_stat.seq_first
		|-> ##2 card_out[1] != $past(card_out[1], 2))
		else $error("step not toggled");
endmodule : mtios_checker
bind mtios_selector mtios_checker chk (.core_clk, .rst, .wb_cyc_i, .wb_stb_i,
	.wb_ack_o, .core_stat, .core_req, .card_out);
`default_nettype wire

/* mtios_plc.sv */
// controller model: drives block number, then command pins
// assumes the bench sets the wanted block and commands
`timescale 1ns/10ps
`default_nettype none
module mtios_plc (
	input wire logic core_clk,
	input wire logic [7:0] want_blk,
	input wire logic [5:0] want_fn,
	output logic [13:0] card_in
);
	logic [1:0] held;
	initial card_in = 14'h0000;
	initial held = 2'h0;
	// commands wait until the block has stood four cycles
	always @(posedge core_clk) begin
		card_in[7:0] <= want_blk;
		if (want_blk != card_in[7:0])
			held <= 2'h0;
		else if (held != 2'h3)
			held <= held + 2'h1;
		if (held == 2'h3 && want_blk == card_in[7:0])
			card_in[13:8] <= want_fn;
	end
endmodule : mtios_plc
`default_nettype wire

/* mtios_selector_tb.sv */
// testbench: bus, pin commands and status pins of the selector
// assumes debounce shortened to 2 cycles, 25 MHz core clock
`timescale 1ns/10ps
`default_nettype none
module mtios_selector_tb;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic [31:0] adr = 32'h0;
	logic [31:0] wdat = 32'h0;
	logic we = 1'b0;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic bhome = 1'b0;
	logic bnext = 1'b0;
	logic [7:0] blk = 8'h00;
	logic [5:0] fn = 6'h00;
	logic [13:0] card_in;
	logic [31:0] rdat;
	logic ack;
	logic [2:0] card_out;
	mtios_pkg::mtios_stat_t stat = 5'h00;
	mtios_pkg::mtios_req_t req;
	int errors = 0;
	int comparisons = 0;
	mtios_selector #(.DEBOUNCE_CYC(2)) uut (.core_clk, .rst, .card_in,
		.base_home_in(bhome), .base_next_in(bnext), .wb_adr_i(adr),
		.wb_dat_i(wdat), .wb_sel_i(4'hF), .wb_we_i(we), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_dat_o(rdat), .wb_ack_o(ack),
		.core_stat(stat), .core_req(req), .card_out);
	mtios_plc plc (.core_clk, .want_blk(blk), .want_fn(fn), .card_in);
	// 40 ns clock
	initial forever #20 core_clk = ~core_clk;
	task automatic test_done;
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : test_done
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : cmp
	// one classic bus cycle, held until ack
	task automatic wb(input logic [31:0] a, input logic [31:0] d,
		input logic w, output logic [31:0] q);
		int n;
		n = 0;
		adr <= a;
		wdat <= d;
		we <= w;
		cyc <= 1'b1;
		stb <= 1'b1;
		do begin
			@(posedge core_clk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		if (ack !== 1'b1) begin
			errors++;
			test_done;
		end
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge core_clk);
	endtask : wb
	task automatic rd(input logic [31:0] a, input logic [31:0] exp);
		logic [31:0] q;
		wb(a, 32'h0, 1'b0, q);
		cmp(q, exp);
	endtask : rd
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] q;
		wb(a, d, 1'b1, q);
	endtask : wr
	// wait bounded for a request bit
	task automatic hit(input int b);
		int n;
		n = 0;
		while (req[b] !== 1'b1) begin
			@(posedge core_clk);
			n++;
			if (n == 60) begin
				errors++;
				test_done;
			end
		end
		cmp({31'h0, req[b]}, 32'h1);
	endtask : hit
	task automatic cmd(input int f, input int b);
		fn[f] <= 1'b1;
		hit(b);
		fn[f] <= 1'b0;
		repeat (12) @(posedge core_clk);
	endtask : cmd
	task automatic t_regs;
		rd(32'h0, 32'h0);
		rd(32'hC, 32'h76543210);
		rd(32'h10, 32'hDCBA9824);
		wr(32'h20, 32'hFFFFFFFF);
		rd(32'h20, 32'h0);
	endtask : t_regs
	task automatic t_cmds;
		blk <= 8'hAE;
		cmd(5, 14);
		cmp({24'h0, req.block}, 32'hAE);
		blk <= 8'h81;
		cmd(5, 14);
		cmp({24'h0, req.block}, 32'h81);
		cmd(4, 13);
		cmd(1, 8);
		fn[3] <= 1'b1;
		hit(11);
		fn[3] <= 1'b0;
		hit(10);
	endtask : t_cmds
	task automatic t_next;
		fn[2] <= 1'b1;
		repeat (20) begin
			@(posedge core_clk);
			cmp({31'h0, req.next_go}, 32'h0);
		end
		stat.in_window <= 1'b1;
		hit(12);
		fn[2] <= 1'b0;
		// base-unit next input ignored while not enabled
		bnext <= 1'b1;
		repeat (6) begin
			@(posedge core_clk);
			cmp({31'h0, req.next_go}, 32'h0);
		end
		bnext <= 1'b0;
		wr(32'h0, 32'h2);
		bnext <= 1'b1;
		hit(12);
		bnext <= 1'b0;
	endtask : t_next
	task automatic t_home;
		wr(32'h0, 32'h0);
		fn[0] <= 1'b1;
		repeat (12) @(posedge core_clk);
		cmp({31'h0, req.home_sw}, 32'h1);
		wr(32'h0, 32'h1);
		repeat (12) @(posedge core_clk);
		cmp({31'h0, req.home_sw}, 32'h0);
		wr(32'h0, 32'h0);
	endtask : t_home
	// status pins: window, then steps first, next, first
	task automatic t_outs;
		cmp({31'h0, card_out[0]}, 32'h1);
		stat.in_window <= 1'b0;
		repeat (3) @(posedge core_clk);
		cmp({31'h0, card_out[0]}, 32'h0);
		stat.seq_active <= 1'b1;
		for (int i = 0; i < 3; i++) begin
			stat.seq_first <= i[0] ^ 1'b1;
			stat.task_started <= 1'b1;
			@(posedge core_clk);
			stat.task_started <= 1'b0;
			repeat (3) @(posedge core_clk);
			cmp({31'h0, card_out[1]}, {31'h0, i[0]});
		end
	endtask : t_outs
	// pulse and level forms of the step output
	task automatic t_modes;
		wr(32'h0, 32'h4);
		stat.seq_first <= 1'b0;
		stat.task_started <= 1'b1;
		@(posedge core_clk);
		stat.task_started <= 1'b0;
		repeat (2) @(posedge core_clk);
		cmp({31'h0, card_out[1]}, 32'h1);
		@(posedge core_clk);
		cmp({31'h0, card_out[1]}, 32'h0);
		wr(32'h0, 32'h8);
		repeat (3) @(posedge core_clk);
		cmp({31'h0, card_out[1]}, 32'h1);
		stat.seq_active <= 1'b0;
		repeat (3) @(posedge core_clk);
		cmp({31'h0, card_out[1]}, 32'h0);
	endtask : t_modes
	// output zero source and warning clear by the clear pin
	task automatic t_warn;
		stat.window0 <= 1'b1;
		repeat (3) @(posedge core_clk);
		cmp({31'h0, card_out[2]}, 32'h1);
		wr(32'h0, 32'h10);
		repeat (2) @(posedge core_clk);
		cmp({31'h0, card_out[2]}, 32'h0);
		wr(32'h4, 32'h30);
		repeat (3) @(posedge core_clk);
		cmp({31'h0, card_out[2]}, 32'h1);
		rd(32'h4, 32'h30);
		fn[1] <= 1'b1;
		repeat (12) @(posedge core_clk);
		rd(32'h4, 32'h0);
		cmp({31'h0, card_out[2]}, 32'h0);
		fn[1] <= 1'b0;
	endtask : t_warn
	// main sequence
	initial begin
		repeat (6) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		t_regs;
		t_cmds;
		t_next;
		t_home;
		t_outs;
		t_modes;
		t_warn;
		test_done;
	end
endmodule : mtios_selector_tb
`default_nettype wire
